/* rtl/dpram_host_consts.vh */
// Constants for the two-port memory host controller.
// Summary of operation
// - Array: select low, flag select high.
// - Hold a strobe high during address changes.
// - Pulse covers turn-off plus set-up when outputs on.
// - Write recovery minimum is zero.
// - Data set-up before end of write: 6 ns.
// - Select held 8 ns; cycle at least 10 ns.
// - Hold write data zero ns after end of write.
// - Wait 5 ns between flag write and read.
// - Slave busy asserted no later than write start.
// - Keep write 8 ns after busy release.
`ifndef DPRAM_HOST_CONSTS_VH
`define DPRAM_HOST_CONSTS_VH
`define ADDR_W 17
`define DATA_W 36
`define FLAG_AW 3
`define CLK_PS 10000
`define T_SETUP_PS 6000
`define T_PULSE_PS 8000
`define T_CYCLE_PS 10000
`define T_HIZ_PS 4000
`define T_ACCESS_PS 10000
`define T_BUSY_DATA_PS 10000
`define T_WR_HOLD_BUSY_PS 8000
`define T_FLAG_WR_RD_PS 5000
`define T_PORT_DATA_PS 22000
`define CNT_W 4
`define CNT_ZERO 4'h0
`define CNT_ONE 4'h1
`define LANES_OFF 4'hf
`endif

/* rtl/pin_sync3.v */
// Three-stage input synchroniser; output changes once stages two and three agree.
`timescale 1ns/10ps
module pin_sync3 #(
  parameter W = 1
) (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  // Data
  input wire [W-1:0] i_async,
  output reg [W-1:0] o_sync
);
  reg [W-1:0] s1_r;
  reg [W-1:0] s2_r;
  reg [W-1:0] s3_r;
  wire [W-1:0] agree;
  genvar g;
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      s1_r <= {W{1'b1}};
      s2_r <= {W{1'b1}};
      s3_r <= {W{1'b1}};
    end else begin
      s1_r <= i_async;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end
  generate
    for (g = 0; g < W; g = g + 1) begin : bit_g
      assign agree[g] = (s2_r[g] == s3_r[g]);
    end
  endgenerate
  // A bit only moves once the two late stages agree, so one glitch never passes.
  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      o_sync <= {W{1'b1}};
    end else begin
      o_sync <= (agree & s3_r) | (~agree & o_sync);
    end
  end
endmodule

/* rtl/dpram_host.v */
// Host controller driving one port of the asynchronous two-port memory.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
module dpram_host (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  // User request
  input wire i_req_valid,
  output wire o_req_ready,
  input wire i_req_write,
  input wire i_req_flag,
  input wire [`ADDR_W-1:0] i_req_addr,
  input wire [`DATA_W-1:0] i_req_wdata,
  input wire [3:0] i_req_lane_n,
  // User answer
  output reg o_rsp_valid,
  output reg [`DATA_W-1:0] o_rsp_rdata,
  output reg o_rsp_busy_seen,
  // Memory port pins
  output reg o_chip_select_n,
  output reg o_flag_select_n,
  output reg o_rw_n,
  output reg o_output_enable_n,
  output reg [3:0] o_byte_lane_enable_n,
  output reg [`ADDR_W-1:0] o_addr,
  input wire [`DATA_W-1:0] i_data,
  output reg [`DATA_W-1:0] o_data,
  output reg o_data_oe,
  input wire i_busy_n
);
  // ----------------------------------------------------------------
  // Cycle counts
  // ----------------------------------------------------------------
  localparam integer SETUP_I = (`T_SETUP_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer PULSE_A_I = (`T_PULSE_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer PULSE_B_I = (`T_HIZ_PS + `T_SETUP_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer PULSE_AB_I = (PULSE_A_I > PULSE_B_I) ? PULSE_A_I : PULSE_B_I;
  localparam integer PULSE_I = (PULSE_AB_I > SETUP_I) ? PULSE_AB_I : SETUP_I;
  localparam integer CYCLE_I = (`T_CYCLE_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer RECOV_I = (CYCLE_I > PULSE_I) ? CYCLE_I - PULSE_I : `CNT_ONE;
  localparam integer RD_ACC_I = (`T_PORT_DATA_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer BUSY_HOLD_I = (`T_WR_HOLD_BUSY_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer FLAG_GAP_I = (`T_FLAG_WR_RD_PS + `CLK_PS - 1) / `CLK_PS;
  localparam integer BUSY_DATA_I = (`T_BUSY_DATA_PS + `CLK_PS - 1) / `CLK_PS;
  localparam [`CNT_W-1:0] PULSE_CYC = PULSE_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RECOV_CYC = RECOV_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] RD_ACC = RD_ACC_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] BUSY_HOLD_CYC = BUSY_HOLD_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] FLAG_GAP_CYC = FLAG_GAP_I[`CNT_W-1:0];
  localparam [`CNT_W-1:0] BUSY_DATA_CYC = BUSY_DATA_I[`CNT_W-1:0];

  // ----------------------------------------------------------------
  // States
  // ----------------------------------------------------------------
  localparam [6:0] ST_IDLE = 7'h01;
  localparam [6:0] ST_WRITE = 7'h02;
  localparam [6:0] ST_BUSYW = 7'h04;
  localparam [6:0] ST_READ = 7'h08;
  localparam [6:0] ST_RECOV = 7'h10;
  localparam [6:0] ST_GAP = 7'h20;
  localparam [6:0] ST_ADDR = 7'h40;

  reg [6:0] state_r;
  reg [`CNT_W-1:0] cnt_r;
  reg last_flag_wr_r;
  reg busy_seen_r;
  // The taken request is kept here, so the user may change its inputs at once.
  reg req_write_r;
  reg req_flag_r;
  reg [`DATA_W-1:0] req_wdata_r;
  wire busy_n_s;

  pin_sync3 #(.W(1)) u_busy_sync (
    .i_sys_clk(i_sys_clk),
    .i_rstn(i_rstn),
    .i_async(i_busy_n),
    .o_sync(busy_n_s)
  );

  assign o_req_ready = (state_r == ST_IDLE);

  // Read data waits the longest access, or the busy-to-data time after a busy release if that is longer.
  function [`CNT_W-1:0] read_wait;
    input seen;
    begin
      read_wait = (seen && BUSY_DATA_CYC > RD_ACC) ? BUSY_DATA_CYC : RD_ACC;
    end
  endfunction

  always @(posedge i_sys_clk or negedge i_rstn) begin
    if (!i_rstn) begin
      state_r <= ST_IDLE;
      cnt_r <= `CNT_ZERO;
      last_flag_wr_r <= 1'b0;
      busy_seen_r <= 1'b0;
      o_rsp_valid <= 1'b0;
      o_rsp_rdata <= {`DATA_W{1'b0}};
      o_rsp_busy_seen <= 1'b0;
      o_chip_select_n <= 1'b1;
      o_flag_select_n <= 1'b1;
      o_rw_n <= 1'b1;
      o_output_enable_n <= 1'b1;
      o_byte_lane_enable_n <= `LANES_OFF;
      o_addr <= {`ADDR_W{1'b0}};
      req_write_r <= 1'b0;
      req_flag_r <= 1'b0;
      req_wdata_r <= {`DATA_W{1'b0}};
      o_data <= {`DATA_W{1'b0}};
      o_data_oe <= 1'b0;
    end else begin
      o_rsp_valid <= 1'b0;
      case (state_r)
        ST_IDLE: begin
          if (i_req_valid) begin
            // address moves while every strobe is high
            o_addr <= i_req_addr;
            o_byte_lane_enable_n <= i_req_lane_n;
            req_write_r <= i_req_write;
            req_flag_r <= i_req_flag;
            req_wdata_r <= i_req_wdata;
            busy_seen_r <= 1'b0;
            if (i_req_flag && !i_req_write && last_flag_wr_r) begin
              state_r <= ST_GAP;
              cnt_r <= FLAG_GAP_CYC;
            end else begin
              state_r <= ST_ADDR;
            end
          end
        end
        ST_GAP: begin
          if (cnt_r <= `CNT_ONE) begin
            state_r <= ST_ADDR;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        ST_ADDR: begin
          // The address has settled for a cycle before any select or strobe falls.
          // array or flag selection
          o_chip_select_n <= req_flag_r;
          o_flag_select_n <= ~req_flag_r;
          last_flag_wr_r <= req_write_r & req_flag_r;
          if (req_write_r) begin
            o_rw_n <= 1'b0;
            o_output_enable_n <= 1'b1;
            o_data <= req_wdata_r;
            o_data_oe <= 1'b1;
            state_r <= ST_WRITE;
            cnt_r <= PULSE_CYC;
          end else begin
            o_output_enable_n <= 1'b0;
            state_r <= ST_READ;
            cnt_r <= read_wait(1'b0);
          end
        end
        ST_WRITE: begin
          if (!busy_n_s && !req_flag_r) begin
            busy_seen_r <= 1'b1;
            state_r <= ST_BUSYW;
            cnt_r <= BUSY_HOLD_CYC;
          end else if (cnt_r <= `CNT_ONE) begin
            // data stable past set-up; held past end
            o_rw_n <= 1'b1;
            o_chip_select_n <= 1'b1;
            o_flag_select_n <= 1'b1;
            o_byte_lane_enable_n <= `LANES_OFF;
            state_r <= ST_RECOV;
            cnt_r <= RECOV_CYC;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        ST_BUSYW: begin
          if (!busy_n_s) begin
            cnt_r <= BUSY_HOLD_CYC;
          end else if (cnt_r <= `CNT_ONE) begin
            state_r <= ST_WRITE;
            cnt_r <= `CNT_ONE;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        ST_READ: begin
          if (!busy_n_s && !busy_seen_r) begin
            busy_seen_r <= 1'b1;
          end
          if (!busy_n_s) begin
            cnt_r <= read_wait(1'b1);
          end else if (cnt_r <= `CNT_ONE) begin
            o_rsp_rdata <= i_data;
            o_rsp_valid <= 1'b1;
            o_rsp_busy_seen <= busy_seen_r;
            o_output_enable_n <= 1'b1;
            o_chip_select_n <= 1'b1;
            o_flag_select_n <= 1'b1;
            o_byte_lane_enable_n <= `LANES_OFF;
            state_r <= ST_RECOV;
            cnt_r <= `CNT_ONE;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        ST_RECOV: begin
          o_data_oe <= 1'b0;
          if (cnt_r <= `CNT_ONE) begin
            if (o_data_oe) begin
              o_rsp_valid <= 1'b1;
              o_rsp_busy_seen <= busy_seen_r;
            end
            state_r <= ST_IDLE;
          end else begin
            cnt_r <= cnt_r - `CNT_ONE;
          end
        end
        default: begin
          state_r <= ST_IDLE;
        end
      endcase
    end
  end
endmodule

/* verification/dpram_host_properties.sv */
// Pin protocol checks for the memory host controller.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
module dpram_host_checker (
  // Clock and reset
  input wire i_sys_clk,
  input wire i_rstn,
  // Watched outputs
  input wire o_rsp_valid,
  input wire o_chip_select_n,
  input wire o_flag_select_n,
  input wire o_rw_n,
  input wire o_output_enable_n,
  input wire [`ADDR_W-1:0] o_addr,
  input wire [`DATA_W-1:0] o_data,
  input wire o_data_oe
);
  default clocking @(posedge i_sys_clk); endclocking
  default disable iff (!i_rstn);
  sequence s_wr_end; $rose(o_rw_n); endsequence
  sequence s_rd_start; $fell(o_output_enable_n); endsequence
  property p_one_sel; o_chip_select_n || o_flag_select_n; endproperty
  a_one_sel: assert property (p_one_sel) else $error("both selects low");
  property p_addr_quiet;
    $changed(o_addr) |-> o_rw_n && o_chip_select_n && o_flag_select_n && $past(o_chip_select_n && o_flag_select_n);
  endproperty
  a_addr_quiet: assert property (p_addr_quiet) else $error("address moved in write");
  property p_no_clash; o_data_oe |-> o_output_enable_n; endproperty
  a_no_clash: assert property (p_no_clash) else $error("data driven against outputs");
  property p_wr_resp; s_wr_end |-> ##[1:3] o_rsp_valid; endproperty
  a_wr_resp: assert property (p_wr_resp) else $error("write not answered");
  property p_setup; s_wr_end |-> $stable(o_data); endproperty
  a_setup: assert property (p_setup) else $error("data moved before write end");
  property p_wr_len; $fell(o_rw_n) |-> ##[1:40] s_wr_end; endproperty
  a_wr_len: assert property (p_wr_len) else $error("write strobe stuck");
  property p_hold; s_wr_end |-> o_data_oe; endproperty
  a_hold: assert property (p_hold) else $error("data released early");
  property p_rd_acc; s_rd_start |-> (o_rw_n && !o_output_enable_n) [*3]; endproperty
  a_rd_acc: assert property (p_rd_acc) else $error("read too short");
endmodule
bind dpram_host dpram_host_checker dpram_host_checker_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn),
  .o_rsp_valid(o_rsp_valid), .o_chip_select_n(o_chip_select_n), .o_flag_select_n(o_flag_select_n),
  .o_rw_n(o_rw_n), .o_output_enable_n(o_output_enable_n), .o_addr(o_addr), .o_data(o_data),
  .o_data_oe(o_data_oe));

/* verification/dpram_port_model.sv */
// Behavioural model of one port of the two-port memory.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
module dpram_port_model (
  // Port pins
  input wire i_cs_n,
  input wire i_fs_n,
  input wire i_rw_n,
  input wire i_oe_n,
  input wire [3:0] i_lane_n,
  input wire [`ADDR_W-1:0] i_addr,
  input wire [`DATA_W-1:0] i_wdata,
  output wire [`DATA_W-1:0] o_rdata,
  output wire o_busy_n,
  // Opposite port holds a matching address
  input wire i_contend
);
  reg [`DATA_W-1:0] mem [0:(1<<`ADDR_W)-1];
  reg [7:0] flag_r = 8'hff;
  integer k;
  wire wr = !i_rw_n && !(i_cs_n && i_fs_n);
  wire [`DATA_W-1:0] rd = i_cs_n ? {`DATA_W{flag_r[i_addr[2:0]]}} : mem[i_addr];
  // busy pin follows contention; this port always loses it.
  // opposite-port data is settled by the time the host reads it.
  assign o_busy_n = !i_contend;
  // drive only while reading, otherwise show the inverse.
  assign o_rdata = (!i_oe_n && i_rw_n && !(i_cs_n && i_fs_n)) ? rd : ~rd;
  // write during the overlap unless inhibited.
  // only this port requests flags here, so a grant is never split.
  always @* begin
    if (wr && !i_fs_n)
      flag_r[i_addr[2:0]] = i_wdata[0];
    if (wr && !i_cs_n && !i_contend)
      for (k = 0; k < 4; k = k + 1)
        if (!i_lane_n[k])
          mem[i_addr][9*k+:9] = i_wdata[9*k+:9];
  end
endmodule

/* verification/testbench.sv */
// Self-checking bench for the memory host controller.
`timescale 1ns/10ps
`include "dpram_host_consts.vh"
`define CHK(a, b) begin n_tests++; if ((a) !== (b)) begin fail_count++; $display("MISMATCH %0t %h %h", $time, a, b); end end
module testbench;
  reg i_sys_clk = 0, i_rstn = 0, i_req_valid = 0, i_req_write = 0, i_req_flag = 0, contend = 0;
  reg [`ADDR_W-1:0] i_req_addr = 0, fa, at [0:5];
  reg [`DATA_W-1:0] i_req_wdata = 0, img, dt [0:5];
  reg [3:0] i_req_lane_n = 0;
  wire o_req_ready, o_rsp_valid, o_rsp_busy_seen, o_chip_select_n, o_flag_select_n, o_rw_n;
  wire o_output_enable_n, o_data_oe, i_busy_n;
  wire [3:0] o_byte_lane_enable_n;
  wire [`ADDR_W-1:0] o_addr;
  wire [`DATA_W-1:0] o_rsp_rdata, o_data, i_data;
  reg [37:0] exp_q [$];
  reg [37:0] e;
  integer fail_count = 0, n_tests = 0, i;
  dpram_host dpram_host_i (.i_sys_clk(i_sys_clk), .i_rstn(i_rstn), .i_req_valid(i_req_valid),
    .o_req_ready(o_req_ready), .i_req_write(i_req_write), .i_req_flag(i_req_flag), .i_req_addr(i_req_addr),
    .i_req_wdata(i_req_wdata), .i_req_lane_n(i_req_lane_n), .o_rsp_valid(o_rsp_valid),
    .o_rsp_rdata(o_rsp_rdata), .o_rsp_busy_seen(o_rsp_busy_seen), .o_chip_select_n(o_chip_select_n),
    .o_flag_select_n(o_flag_select_n), .o_rw_n(o_rw_n), .o_output_enable_n(o_output_enable_n),
    .o_byte_lane_enable_n(o_byte_lane_enable_n), .o_addr(o_addr), .i_data(i_data), .o_data(o_data),
    .o_data_oe(o_data_oe), .i_busy_n(i_busy_n));
  dpram_port_model dpram_port_model_i (.i_cs_n(o_chip_select_n), .i_fs_n(o_flag_select_n), .i_rw_n(o_rw_n),
    .i_oe_n(o_output_enable_n), .i_lane_n(o_byte_lane_enable_n), .i_addr(o_addr),
    .i_wdata(o_data_oe ? o_data : ~o_data), .o_rdata(i_data), .o_busy_n(i_busy_n), .i_contend(contend));
  initial forever #5 i_sys_clk = ~i_sys_clk;
  task conclude;
    begin
      $display("checks %0d mismatches %0d", n_tests, fail_count);
      if (fail_count == 0 && n_tests > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
    end
  endtask
  // Issues one request and notes what its answer must carry.
  task op(input w, f, input [`ADDR_W-1:0] a, input [`DATA_W-1:0] d, input [3:0] ln, input [37:0] x);
    integer n;
    begin
      @(posedge i_sys_clk);
      #1 {i_req_valid, i_req_write, i_req_flag, i_req_addr, i_req_wdata, i_req_lane_n} = {1'b1, w, f, a, d, ln};
      n = 0;
      do begin @(negedge i_sys_clk); n++; end while (o_req_ready !== 1'b1 && n < 200);
      if (n >= 200) begin fail_count++; conclude; end
      exp_q.push_back(x);
      @(posedge i_sys_clk);
      #1 i_req_valid = 0;
    end
  endtask
  always @(negedge i_sys_clk) begin
    if (o_rsp_valid === 1'b1) begin
      if (exp_q.size() == 0) `CHK(1'b1, 1'b0)
      else begin
        e = exp_q.pop_front();
        `CHK(o_rsp_busy_seen, e[36])
        if (e[37]) `CHK(o_rsp_rdata, e[35:0])
      end
    end
  end
  initial begin
    i = $urandom(31);
    repeat (6) @(posedge i_sys_clk);
    #1 i_rstn = 1;
    for (i = 0; i < 6; i++) begin
      at[i] = i == 0 ? 17'h0_0000 : i == 1 ? 17'h1_ffff : (17'($urandom) & 17'h1_fff8) | 17'(i);
      dt[i] = {4'($urandom), $urandom};
      op(1, 0, at[i], dt[i], 4'h0, 38'h0);
    end
    for (i = 0; i < 6; i++) op(0, 0, at[i], 36'h0, 4'h0, {2'b10, dt[i]});
    img = dt[2] ^ 36'h0_07fc_01ff;
    op(1, 0, at[2], ~dt[2], 4'ha, 38'h0);
    op(0, 0, at[2], 36'h0, 4'h0, {2'b10, img});
    for (i = 0; i < 8; i++) begin
      fa = 17'($urandom) & 17'h1_fff8 | 17'(i);
      op(1, 1, fa, 36'h0, 4'h0, 38'h0);
      op(0, 1, fa, 36'h0, 4'h0, {2'b10, 36'h0});
      op(1, 1, fa, 36'h1, 4'h0, 38'h0);
      op(0, 1, fa, 36'h0, 4'h0, {2'b10, {36{1'b1}}});
    end
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge i_sys_clk);
    #1 contend = 1;
    repeat (6) @(posedge i_sys_clk);
    fork
      op(1, 0, at[3], ~dt[3], 4'h0, {2'b01, 36'h0});
      begin repeat (20) @(posedge i_sys_clk); #1 contend = 0; end
    join
    op(0, 0, at[3], 36'h0, 4'h0, {2'b10, ~dt[3]});
    for (i = 0; i < 100 && exp_q.size() > 0; i++) @(posedge i_sys_clk);
    if (exp_q.size() > 0) fail_count++;
    conclude;
  end
endmodule
